// ==== nv_guard_pkg.sv ====
package nv_guard_pkg;

  // ==========================================================
  // register map (byte addresses)
  localparam logic [7:0] ADDR_HIGH_OFS = 8'h00;
  localparam logic [7:0] ADDR_LOW_OFS  = 8'h04;
  localparam logic [7:0] DATA_OFS      = 8'h08;
  localparam logic [7:0] CONTROL_OFS   = 8'h0C;
  localparam logic [7:0] STATUS_OFS    = 8'h10;

  // ==========================================================
  // reset values and field positions
  localparam logic [7:0] ADDR_HIGH_RST = 8'h80;
  localparam logic [7:0] ADDR_LOW_RST  = 8'h00;
  localparam logic [7:0] CONTROL_RST   = 8'h00;
  localparam logic [7:0] SECURE_HIGH   = 8'h80;
  localparam logic [7:0] SECURE_LOW    = 8'h00;
  localparam logic [7:0] ARRAY_HIGH    = 8'h00;
  localparam logic [7:0] SECURE_PWRUP  = 8'h00;
  localparam int         CTL_BUSY_BIT  = 5;
  localparam logic [7:0] CTL_WR_MASK   = 8'hCF;
  localparam logic [3:0] MODE_BYTE     = 4'h0;
  localparam logic [3:0] MODE_ROW_ERA  = 4'hC;
  localparam logic [3:0] MODE_BLK_ERA  = 4'hA;
  localparam int         ST_PROTECT    = 0;
  localparam int         ST_BUSY       = 1;
  localparam int         ST_EXT_EXEC   = 2;
  localparam int         ST_EXT_ONLY   = 3;
  localparam int         ST_BLOCKED    = 4;
  localparam logic [15:0] ROM_LIMIT    = 16'h1000;
  localparam int         ROW_BYTES     = 8;
  localparam int         ARRAY_BYTES   = 256;
  localparam int         MAJORITY_MIN  = 3;

  // ==========================================================
  // timing
  localparam int CLOCK_PERIOD_PS = 4000;
  localparam int NV_CYCLE_TIME_US = 2000;
  localparam int NV_CYCLE_CLKS =
    (NV_CYCLE_TIME_US * 1000000 + CLOCK_PERIOD_PS - 1) / CLOCK_PERIOD_PS;
  localparam int SEQ_CNT_W = 20;

  // ==========================================================
  // types
  typedef enum logic [1:0] {
    OP_WRITE     = 2'b00,
    OP_ROW_ERASE = 2'b01,
    OP_BLK_ERASE = 2'b10
  } nv_op_t;

  typedef enum logic [1:0] {
    SEQ_IDLE   = 2'b00,
    SEQ_RUN    = 2'b01,
    SEQ_COMMIT = 2'b11
  } seq_state_t;

endpackage : nv_guard_pkg

// ==== nv_seq_if.sv ====
`timescale 1ns/1ps
`default_nettype none
interface nv_seq_if;
  logic                 start;
  nv_guard_pkg::nv_op_t op;
  logic [7:0]           addr;
  logic                 sec_sel;
  logic [7:0]           wdata;
  logic                 abort;
  logic                 busy;
  logic [7:0]           rd_data;
  logic [7:0]           sec_byte;

  modport ctrl  (output start, op, addr, sec_sel, wdata, abort,
                 input  busy, rd_data, sec_byte);
  modport store (input  start, op, addr, sec_sel, wdata, abort,
                 output busy, rd_data, sec_byte);
endinterface : nv_seq_if
`default_nettype wire

// ==== nv_store.sv ====
`timescale 1ns/1ps
`default_nettype none
module nv_store #(
  parameter int unsigned CYCLE_CLKS = nv_guard_pkg::NV_CYCLE_CLKS
) (
  input  wire logic clock,
  input  wire logic arst_n,
  nv_seq_if.store   seq
);

  logic [7:0]                              mem [nv_guard_pkg::ARRAY_BYTES];
  logic [7:0]                              sec_reg;
  nv_guard_pkg::seq_state_t                state_reg;
  logic [nv_guard_pkg::SEQ_CNT_W-1:0]      cnt_reg;
  nv_guard_pkg::nv_op_t                    op_reg;
  logic [7:0]                              addr_reg;
  logic                                    sec_sel_reg;
  logic [7:0]                              wdata_reg;

  // ==========================================================
  // sequencer
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      state_reg <= nv_guard_pkg::SEQ_IDLE;
      cnt_reg   <= '0;
    end else begin
      case (state_reg)
        nv_guard_pkg::SEQ_IDLE: begin
          if (seq.start) begin
            state_reg <= nv_guard_pkg::SEQ_RUN;
            cnt_reg   <= nv_guard_pkg::SEQ_CNT_W'(CYCLE_CLKS - 1);
          end
        end
        nv_guard_pkg::SEQ_RUN: begin
          if (seq.abort) begin
            state_reg <= nv_guard_pkg::SEQ_IDLE;
          end else if (cnt_reg == '0) begin
            state_reg <= nv_guard_pkg::SEQ_COMMIT;
          end else begin
            cnt_reg <= cnt_reg - 1'b1;
          end
        end
        nv_guard_pkg::SEQ_COMMIT: state_reg <= nv_guard_pkg::SEQ_IDLE;
        default: state_reg <= nv_guard_pkg::SEQ_IDLE;
      endcase
    end
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      op_reg      <= nv_guard_pkg::OP_WRITE;
      addr_reg    <= '0;
      sec_sel_reg <= 1'b0;
      wdata_reg   <= '0;
    end else if (seq.start && state_reg == nv_guard_pkg::SEQ_IDLE) begin
      op_reg      <= seq.op;
      addr_reg    <= seq.addr;
      sec_sel_reg <= seq.sec_sel;
      wdata_reg   <= seq.wdata;
    end
  end

  // ==========================================================
  // array and protection byte
  always_ff @(posedge clock) begin
    if (state_reg == nv_guard_pkg::SEQ_COMMIT) begin
      case (op_reg)
        nv_guard_pkg::OP_WRITE: begin
          if (!sec_sel_reg) begin
            mem[addr_reg] <= wdata_reg;
          end
        end
        nv_guard_pkg::OP_ROW_ERASE: begin
          for (int i = 0; i < nv_guard_pkg::ROW_BYTES; i++) begin
            mem[{addr_reg[7:3], 3'(i)}] <= '0;
          end
        end
        nv_guard_pkg::OP_BLK_ERASE: begin
          for (int i = 0; i < nv_guard_pkg::ARRAY_BYTES; i++) begin
            mem[i] <= '0;
          end
        end
        default: ;
      endcase
    end
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      sec_reg <= nv_guard_pkg::SECURE_PWRUP;
    end else if (state_reg == nv_guard_pkg::SEQ_COMMIT) begin
      if (op_reg == nv_guard_pkg::OP_BLK_ERASE) begin
        sec_reg <= '0;
      end else if (op_reg == nv_guard_pkg::OP_WRITE && sec_sel_reg) begin
        sec_reg <= wdata_reg;
      end
    end
  end

  assign seq.busy     = (state_reg != nv_guard_pkg::SEQ_IDLE);
  assign seq.rd_data  = seq.sec_sel ? sec_reg : mem[seq.addr];
  assign seq.sec_byte = sec_reg;

endmodule : nv_store
`default_nettype wire

// ==== nv_guard.sv ====
// Implementation choices: the address map and the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module nv_guard #(
  parameter int unsigned CYCLE_CLKS  = nv_guard_pkg::NV_CYCLE_CLKS,
  parameter bit          ROM_PROTECT = 1'b0
) (
  input  wire logic        CLOCK,
  input  wire logic        ARST_N,
  input  wire logic        PSEL,
  input  wire logic        PENABLE,
  input  wire logic        PWRITE,
  input  wire logic [7:0]  PADDR,
  input  wire logic [31:0] PWDATA,
  output var  logic [31:0] PRDATA,
  output logic             PREADY,
  output logic             PSLVERR,
  input  wire logic        EXTERNAL_ACCESS_PIN_N,
  input  wire logic [15:0] FETCH_ADDR,
  input  wire logic        TABLE_READ_INSTR,
  input  wire logic [15:0] TABLE_READ_ADDR,
  input  wire logic        LOW_POWER_REQ,
  output var  logic        TABLE_READ_GRANT,
  output var  logic        INT_ROM_DENY,
  output var  logic        PROTECT_FLAG,
  output var  logic        ERASE_WRITE_BUSY,
  output var  logic        EXT_ONLY_MODE
);

  // ==========================================================
  // helpers
  function automatic logic majority_set(input logic [3:0] bits);
    int n;
    n = 0;
    for (int i = 0; i < 4; i++) begin
      n = n + int'(bits[i]);
    end
    return n >= nv_guard_pkg::MAJORITY_MIN;
  endfunction : majority_set

  function automatic logic in_low_rom(input logic [15:0] a);
    return a < nv_guard_pkg::ROM_LIMIT;
  endfunction : in_low_rom

  nv_seq_if seq ();

  nv_store #(
    .CYCLE_CLKS(CYCLE_CLKS)
  ) u_store (
    .clock (CLOCK),
    .arst_n(ARST_N),
    .seq   (seq.store)
  );

  logic [7:0] nv_addr_high_reg;
  logic [7:0] nv_addr_low_reg;
  logic [7:0] nv_control_reg;
  logic       protect_flag_reg;
  logic       ext_only_reg;
  logic       strap_done_reg;
  logic       blocked_reg;
  logic       tbl_active_reg;
  logic       tbl_ext_reg;
  logic       ext_now;
  logic       ext_eff;
  logic       locked;
  logic       sec_sel;
  logic       arr_sel;
  logic       setup;
  logic       access;
  logic       mapped;
  logic       data_wr;
  logic       start_ok;
  logic [3:0] mode;
  logic [7:0] status;

  // ==========================================================
  // apb decode
  assign setup  = PSEL && !PENABLE;
  assign access = PSEL && PENABLE;
  assign mapped = (PADDR == nv_guard_pkg::ADDR_HIGH_OFS) ||
                  (PADDR == nv_guard_pkg::ADDR_LOW_OFS)  ||
                  (PADDR == nv_guard_pkg::DATA_OFS)      ||
                  (PADDR == nv_guard_pkg::CONTROL_OFS)   ||
                  (PADDR == nv_guard_pkg::STATUS_OFS);
  assign PREADY  = 1'b1;
  assign PSLVERR = access && !mapped;
  assign data_wr = access && PWRITE && (PADDR == nv_guard_pkg::DATA_OFS);

  // ==========================================================
  // execution mode
  always_ff @(posedge CLOCK or negedge ARST_N) begin
    if (!ARST_N) begin
      ext_only_reg   <= 1'b0;
      strap_done_reg <= 1'b0;
    end else if (!strap_done_reg) begin
      ext_only_reg   <= !EXTERNAL_ACCESS_PIN_N;
      strap_done_reg <= 1'b1;
    end
  end

  assign ext_now = ext_only_reg || !in_low_rom(FETCH_ADDR);

  always_ff @(posedge CLOCK or negedge ARST_N) begin
    if (!ARST_N) begin
      tbl_active_reg <= 1'b0;
      tbl_ext_reg    <= 1'b0;
    end else begin
      tbl_active_reg <= TABLE_READ_INSTR;
      if (TABLE_READ_INSTR && !tbl_active_reg) begin
        tbl_ext_reg <= ext_now;
      end
    end
  end

  assign ext_eff = tbl_active_reg ? tbl_ext_reg : ext_now;

  // ==========================================================
  // rom gate
  always_ff @(posedge CLOCK or negedge ARST_N) begin
    if (!ARST_N) begin
      TABLE_READ_GRANT <= 1'b0;
      INT_ROM_DENY     <= 1'b0;
    end else begin
      // only a grant and a deny flag leave here; rom data never reaches a port
      TABLE_READ_GRANT <= TABLE_READ_INSTR &&
                          (!in_low_rom(TABLE_READ_ADDR) || !ext_eff);
      INT_ROM_DENY     <= ROM_PROTECT && ext_eff;
    end
  end

  // ==========================================================
  // protection flag
  always_ff @(posedge CLOCK or negedge ARST_N) begin
    if (!ARST_N) begin
      protect_flag_reg <= 1'b0;
    end else begin
      protect_flag_reg <= majority_set(seq.sec_byte[3:0]);
    end
  end

  assign locked = protect_flag_reg && ext_now;

  // ==========================================================
  // registers
  always_ff @(posedge CLOCK or negedge ARST_N) begin
    if (!ARST_N) begin
      nv_addr_high_reg <= nv_guard_pkg::ADDR_HIGH_RST;
      nv_addr_low_reg  <= nv_guard_pkg::ADDR_LOW_RST;
      nv_control_reg   <= nv_guard_pkg::CONTROL_RST;
    end else if (access && PWRITE) begin
      case (PADDR)
        nv_guard_pkg::ADDR_HIGH_OFS: nv_addr_high_reg <= PWDATA[7:0];
        nv_guard_pkg::ADDR_LOW_OFS:  nv_addr_low_reg  <= PWDATA[7:0];
        nv_guard_pkg::CONTROL_OFS:
          nv_control_reg <= PWDATA[7:0] & nv_guard_pkg::CTL_WR_MASK;
        default: ;
      endcase
    end
  end

  // ==========================================================
  // start of array operations
  assign mode    = nv_control_reg[3:0];
  assign sec_sel = (nv_addr_high_reg == nv_guard_pkg::SECURE_HIGH) &&
                   (nv_addr_low_reg == nv_guard_pkg::SECURE_LOW);
  assign arr_sel = (nv_addr_high_reg == nv_guard_pkg::ARRAY_HIGH);

  always_comb begin
    start_ok = 1'b0;
    seq.op   = nv_guard_pkg::OP_WRITE;
    if (mode == nv_guard_pkg::MODE_BLK_ERA) begin
      seq.op   = nv_guard_pkg::OP_BLK_ERASE;
      start_ok = 1'b1;
    end else if (!locked) begin
      if (mode == nv_guard_pkg::MODE_BYTE) begin
        start_ok = arr_sel || sec_sel;
      end else if (mode == nv_guard_pkg::MODE_ROW_ERA) begin
        seq.op   = nv_guard_pkg::OP_ROW_ERASE;
        start_ok = arr_sel;
      end
    end
  end

  assign seq.start   = data_wr && start_ok && !seq.busy;
  assign seq.addr    = nv_addr_low_reg;
  assign seq.sec_sel = sec_sel;
  assign seq.wdata   = PWDATA[7:0];
  assign seq.abort   = LOW_POWER_REQ;

  always_ff @(posedge CLOCK or negedge ARST_N) begin
    if (!ARST_N) begin
      blocked_reg <= 1'b0;
    end else if (data_wr) begin
      blocked_reg <= !seq.start;
    end
  end

  // ==========================================================
  // read path
  always_comb begin
    status = '0;
    status[nv_guard_pkg::ST_PROTECT]  = protect_flag_reg;
    status[nv_guard_pkg::ST_BUSY]     = seq.busy;
    status[nv_guard_pkg::ST_EXT_EXEC] = ext_now;
    status[nv_guard_pkg::ST_EXT_ONLY] = ext_only_reg;
    status[nv_guard_pkg::ST_BLOCKED]  = blocked_reg;
  end

  always_ff @(posedge CLOCK or negedge ARST_N) begin
    if (!ARST_N) begin
      PRDATA <= '0;
    end else if (setup && !PWRITE) begin
      PRDATA <= '0;
      case (PADDR)
        nv_guard_pkg::ADDR_HIGH_OFS: PRDATA[7:0] <= nv_addr_high_reg;
        nv_guard_pkg::ADDR_LOW_OFS:  PRDATA[7:0] <= nv_addr_low_reg;
        nv_guard_pkg::DATA_OFS: begin
          if (!seq.busy && !locked && (arr_sel || sec_sel)) begin
            PRDATA[7:0] <= seq.rd_data;
          end
        end
        nv_guard_pkg::CONTROL_OFS: begin
          PRDATA[7:0] <= nv_control_reg;
          PRDATA[nv_guard_pkg::CTL_BUSY_BIT] <= seq.busy;
        end
        nv_guard_pkg::STATUS_OFS: PRDATA[7:0] <= status;
        default: ;
      endcase
    end
  end

  // ==========================================================
  // status outputs
  always_ff @(posedge CLOCK or negedge ARST_N) begin
    if (!ARST_N) begin
      PROTECT_FLAG     <= 1'b0;
      ERASE_WRITE_BUSY <= 1'b0;
      EXT_ONLY_MODE    <= 1'b0;
    end else begin
      PROTECT_FLAG     <= protect_flag_reg;
      ERASE_WRITE_BUSY <= seq.busy;
      EXT_ONLY_MODE    <= ext_only_reg;
    end
  end

endmodule : nv_guard
`default_nettype wire

// ==== nv_guard_monitor.sv ====
`timescale 1ns/1ps
`default_nettype none
module nv_guard_monitor #(
  parameter int unsigned CYCLE_CLKS  = 8,
  parameter bit          ROM_PROTECT = 1'b0
) (
  input wire logic        CLOCK,
  input wire logic        ARST_N,
  input wire logic        PSEL,
  input wire logic        PENABLE,
  input wire logic        PWRITE,
  input wire logic [7:0]  PADDR,
  input wire logic [31:0] PRDATA,
  input wire logic [15:0] FETCH_ADDR,
  input wire logic        TABLE_READ_INSTR,
  input wire logic [15:0] TABLE_READ_ADDR,
  input wire logic        LOW_POWER_REQ,
  input wire logic        TABLE_READ_GRANT,
  input wire logic        INT_ROM_DENY,
  input wire logic        PROTECT_FLAG,
  input wire logic        ERASE_WRITE_BUSY,
  input wire logic        EXT_ONLY_MODE
);
  logic [7:0] len_reg;
  logic       lp_reg;
  logic [1:0] age_reg;

  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (!ARST_N);

  // ==========
  // busy run length, abort seen, edges since reset
  always_ff @(posedge CLOCK or negedge ARST_N) begin
    if (!ARST_N) begin
      len_reg <= 8'h00;
      lp_reg  <= 1'b0;
      age_reg <= 2'h0;
    end else begin
      len_reg <= ERASE_WRITE_BUSY ? len_reg + 8'h01 : 8'h00;
      lp_reg  <= ERASE_WRITE_BUSY && (lp_reg || LOW_POWER_REQ);
      if (age_reg != 2'h3) age_reg <= age_reg + 2'h1;
    end
  end

  // ==========
  // assertions
  grant_ext_a:
    assert property ($rose(TABLE_READ_INSTR) && FETCH_ADDR >= 16'h1000
      && TABLE_READ_ADDR < 16'h1000 |=> !TABLE_READ_GRANT)
    else $error("low rom table read granted to external code");
  grant_int_a:
    assert property ($rose(TABLE_READ_INSTR) && FETCH_ADDR < 16'h1000 && !EXT_ONLY_MODE
      |=> TABLE_READ_GRANT)
    else $error("table read refused to internal code");
  grant_freeze_a:
    assert property (TABLE_READ_INSTR && $past(TABLE_READ_INSTR) && $stable(TABLE_READ_ADDR)
      |=> $stable(TABLE_READ_GRANT))
    else $error("grant changed within one table read");
  rom_deny_a:
    assert property (age_reg == 2'h3 && $stable(FETCH_ADDR) && !TABLE_READ_INSTR
      && !$past(TABLE_READ_INSTR) |=> INT_ROM_DENY ==
      (ROM_PROTECT && (EXT_ONLY_MODE || $past(FETCH_ADDR) >= 16'h1000)))
    else $error("rom deny wrong");
  strap_hold_a:
    assert property (age_reg == 2'h3 |-> $stable(EXT_ONLY_MODE))
    else $error("external-only mode changed outside reset");
  busy_len_a:
    assert property ($fell(ERASE_WRITE_BUSY) && !lp_reg |-> len_reg == CYCLE_CLKS + 1)
    else $error("busy length wrong");
  flag_change_a:
    assert property ($changed(PROTECT_FLAG) |-> $past(ERASE_WRITE_BUSY)
      || $past(ERASE_WRITE_BUSY, 2) || $past(ERASE_WRITE_BUSY, 3))
    else $error("protect flag moved without an array operation");
  busy_read_a:
    assert property (PSEL && !PENABLE && !PWRITE && PADDR == nv_guard_pkg::DATA_OFS
      && ERASE_WRITE_BUSY ##1 ERASE_WRITE_BUSY |-> PRDATA == 32'h0000_0000)
    else $error("data read while busy");

  cover property ($fell(ERASE_WRITE_BUSY));
  cover property ($rose(PROTECT_FLAG));
  cover property ($fell(PROTECT_FLAG));
  cover property ($rose(TABLE_READ_INSTR) && FETCH_ADDR >= 16'h1000);
endmodule : nv_guard_monitor

bind nv_guard nv_guard_monitor #(.CYCLE_CLKS(CYCLE_CLKS), .ROM_PROTECT(ROM_PROTECT))
  nv_guard_monitor_i (.CLOCK(CLOCK), .ARST_N(ARST_N), .PSEL(PSEL), .PENABLE(PENABLE),
  .PWRITE(PWRITE), .PADDR(PADDR), .PRDATA(PRDATA), .FETCH_ADDR(FETCH_ADDR),
  .TABLE_READ_INSTR(TABLE_READ_INSTR), .TABLE_READ_ADDR(TABLE_READ_ADDR),
  .LOW_POWER_REQ(LOW_POWER_REQ), .TABLE_READ_GRANT(TABLE_READ_GRANT),
  .INT_ROM_DENY(INT_ROM_DENY), .PROTECT_FLAG(PROTECT_FLAG),
  .ERASE_WRITE_BUSY(ERASE_WRITE_BUSY), .EXT_ONLY_MODE(EXT_ONLY_MODE));
`default_nettype wire

// ==== cpu_core_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module cpu_core_model (
  input  wire logic        clock,
  input  wire logic [31:0] prdata,
  input  wire logic        pready,
  input  wire logic        pslverr,
  input  wire logic        busy,
  input  wire logic        grant,
  output var  logic        psel,
  output var  logic        penable,
  output var  logic        pwrite,
  output var  logic [7:0]  paddr,
  output var  logic [31:0] pwdata,
  output var  logic [15:0] fetch_addr,
  output var  logic        tr_instr,
  output var  logic [15:0] tr_addr,
  output var  logic        low_power
);
  logic err;

  initial begin
    {psel, penable, tr_instr, low_power, err} = 5'h00;
    fetch_addr = 16'h0000;
  end

  // ==========
  // apb transfer, held until pready
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q);
    @(posedge clock);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    do @(posedge clock); while (pready !== 1'b1);
    q = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : xfer

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [31:0] q;
    xfer(1'b1, a, {24'h00_0000, d}, q);
  endtask : wr

  task automatic nv_addr(input logic [15:0] a);
    wr(nv_guard_pkg::ADDR_HIGH_OFS, a[15:8]);
    wr(nv_guard_pkg::ADDR_LOW_OFS, a[7:0]);
  endtask : nv_addr

  // byte mode: address first, then data
  task automatic nv_write(input logic [15:0] a, input logic [7:0] d);
    nv_addr(a);
    wr(nv_guard_pkg::DATA_OFS, d);
  endtask : nv_write

  // block erase: address, mode, then any data
  task automatic blk_erase;
    nv_addr(16'h8000);
    wr(nv_guard_pkg::CONTROL_OFS, 8'h0A);
    wr(nv_guard_pkg::DATA_OFS, 8'h5A);
  endtask : blk_erase

  // low power request, polite waits for busy clear
  task automatic lp_pulse(input bit polite);
    for (int i = 0; i < 100 && polite && busy !== 1'b0; i++) @(posedge clock);
    @(posedge clock);
    low_power <= 1'b1;
    @(posedge clock);
    low_power <= 1'b0;
  endtask : lp_pulse

  task automatic jump(input logic [15:0] f);
    @(posedge clock);
    fetch_addr <= f;
    repeat (2) @(posedge clock);
  endtask : jump

  // table read, fetch moves after its first cycle
  task automatic tread(input logic [15:0] f0, input logic [15:0] f1,
                       input logic [15:0] a, output logic g);
    jump(f0);
    tr_instr <= 1'b1;
    tr_addr <= a;
    @(posedge clock);
    fetch_addr <= f1;
    @(posedge clock);
    @(negedge clock);
    g = grant;
    @(posedge clock);
    tr_instr <= 1'b0;
  endtask : tread
endmodule : cpu_core_model
`default_nettype wire

// ==== testbench.sv ====
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic        clock = 1'b0;
  logic        arst_n = 1'b0;
  logic        strap_n = 1'b1;
  logic        psel, penable, pwrite, pready, pslverr, tr_instr, low_power;
  logic        grant, deny, flag, busy, ext_only, g;
  logic [7:0]  paddr;
  logic [15:0] fetch_addr, tr_addr;
  logic [31:0] pwdata, prdata, q;
  int          bad_count = 0;
  int          checks = 0;
  int          cycles = 0;

  always #2 clock = ~clock;

  nv_guard #(.CYCLE_CLKS(8), .ROM_PROTECT(1'b1)) nv_guard_i (.CLOCK(clock), .ARST_N(arst_n),
    .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata),
    .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr), .EXTERNAL_ACCESS_PIN_N(strap_n),
    .FETCH_ADDR(fetch_addr), .TABLE_READ_INSTR(tr_instr), .TABLE_READ_ADDR(tr_addr),
    .LOW_POWER_REQ(low_power), .TABLE_READ_GRANT(grant), .INT_ROM_DENY(deny),
    .PROTECT_FLAG(flag), .ERASE_WRITE_BUSY(busy), .EXT_ONLY_MODE(ext_only));

  cpu_core_model cpu_core_model_i (.clock(clock), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .busy(busy), .grant(grant), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .fetch_addr(fetch_addr),
    .tr_instr(tr_instr), .tr_addr(tr_addr), .low_power(low_power));

  // ==========
  // helpers
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] s);
    checks++;
    if (s !== e) begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", n, e, s);
    end
  endtask : chk

  task automatic rd(input logic [7:0] a);
    cpu_core_model_i.xfer(1'b0, a, 32'h0000_0000, q);
  endtask : rd

  task automatic settle;
    repeat (3) @(posedge clock);
    for (int i = 0; i < 40 && busy !== 1'b0; i++) @(posedge clock);
    repeat (3) @(posedge clock);
  endtask : settle

  task automatic do_reset(input logic pin);
    @(posedge clock);
    arst_n <= 1'b0;
    strap_n <= pin;
    repeat (8) @(posedge clock);
    arst_n <= 1'b1;
    repeat (3) @(posedge clock);
  endtask : do_reset

  // ==========
  // scenarios
  task automatic t_regs;
    rd(nv_guard_pkg::ADDR_HIGH_OFS);
    chk("addr high", 8'h80, q[7:0]);
    rd(nv_guard_pkg::STATUS_OFS);
    chk("status", 8'h00, q[7:0]);
    rd(8'h14);
    chk("unmapped", 8'h01, {q[7:1], cpu_core_model_i.err});
    cpu_core_model_i.wr(nv_guard_pkg::CONTROL_OFS, 8'h2A);
    rd(nv_guard_pkg::CONTROL_OFS);
    chk("control", 8'h0A, q[7:0]);
    cpu_core_model_i.wr(nv_guard_pkg::CONTROL_OFS, 8'h00);
  endtask : t_regs

  task automatic t_vote;
    logic [7:0] v [7] = '{8'hFF, 8'h07, 8'h03, 8'h0E, 8'h05, 8'h0B, 8'h00};
    logic [6:0] e = 7'h2B;
    cpu_core_model_i.nv_write(16'h0010, 8'h5A);
    settle;
    rd(nv_guard_pkg::DATA_OFS);
    chk("byte", 8'h5A, q[7:0]);
    for (int i = 0; i < 7; i++) begin
      cpu_core_model_i.nv_write(16'h8000, v[i]);
      settle;
      chk("flag", 8'(e[i]), 8'(flag));
      rd(nv_guard_pkg::DATA_OFS);
      chk("prot byte", v[i], q[7:0]);
    end
  endtask : t_vote

  task automatic t_lock;
    cpu_core_model_i.nv_write(16'h8000, 8'hFF);
    settle;
    cpu_core_model_i.jump(16'h1000);
    cpu_core_model_i.nv_write(16'h8000, 8'h00);
    repeat (4) @(posedge clock);
    chk("busy", 8'h00, 8'(busy));
    chk("flag", 8'h01, 8'(flag));
    cpu_core_model_i.wr(nv_guard_pkg::CONTROL_OFS, 8'h0C);
    cpu_core_model_i.wr(nv_guard_pkg::DATA_OFS, 8'h00);
    repeat (4) @(posedge clock);
    chk("busy", 8'h00, 8'(busy));
    rd(nv_guard_pkg::STATUS_OFS);
    chk("status", 8'h15, q[7:0]);
    rd(nv_guard_pkg::DATA_OFS);
    chk("locked read", 8'h00, q[7:0]);
  endtask : t_lock

  task automatic t_erase;
    cpu_core_model_i.blk_erase;
    settle;
    chk("flag", 8'h00, 8'(flag));
    cpu_core_model_i.jump(16'h0000);
    cpu_core_model_i.wr(nv_guard_pkg::CONTROL_OFS, 8'h00);
    cpu_core_model_i.nv_addr(16'h0010);
    rd(nv_guard_pkg::DATA_OFS);
    chk("erased", 8'h00, q[7:0]);
    cpu_core_model_i.nv_write(16'h0013, 8'h77);
    settle;
    rd(nv_guard_pkg::DATA_OFS);
    chk("byte", 8'h77, q[7:0]);
    cpu_core_model_i.wr(nv_guard_pkg::CONTROL_OFS, 8'h0C);
    cpu_core_model_i.wr(nv_guard_pkg::DATA_OFS, 8'h00);
    settle;
    cpu_core_model_i.wr(nv_guard_pkg::CONTROL_OFS, 8'h00);
    rd(nv_guard_pkg::DATA_OFS);
    chk("row erased", 8'h00, q[7:0]);
  endtask : t_erase

  task automatic t_busy;
    cpu_core_model_i.nv_write(16'h0010, 8'h33);
    repeat (3) @(posedge clock);
    chk("busy", 8'h01, 8'(busy));
    cpu_core_model_i.wr(nv_guard_pkg::DATA_OFS, 8'h44);
    rd(nv_guard_pkg::DATA_OFS);
    chk("busy read", 8'h00, q[7:0]);
    settle;
    rd(nv_guard_pkg::DATA_OFS);
    chk("byte", 8'h33, q[7:0]);
    rd(nv_guard_pkg::STATUS_OFS);
    chk("status", 8'h10, q[7:0]);
    cpu_core_model_i.nv_write(16'h8000, 8'hFF);
    repeat (4) @(posedge clock);
    cpu_core_model_i.lp_pulse(1'b0);
    settle;
    chk("flag", 8'h00, 8'(flag));
    cpu_core_model_i.lp_pulse(1'b1);
  endtask : t_busy

  task automatic t_table;
    cpu_core_model_i.tread(16'h0000, 16'h0000, 16'h0100, g);
    chk("grant", 8'h01, 8'(g));
    cpu_core_model_i.tread(16'h1000, 16'h1000, 16'h0100, g);
    chk("grant", 8'h00, 8'(g));
    cpu_core_model_i.tread(16'h1000, 16'h1000, 16'h2000, g);
    chk("grant", 8'h01, 8'(g));
    cpu_core_model_i.tread(16'h0000, 16'h1000, 16'h0100, g);
    chk("grant", 8'h01, 8'(g));
    cpu_core_model_i.jump(16'h1000);
    chk("deny", 8'h01, 8'(deny));
    cpu_core_model_i.jump(16'h0000);
    chk("deny", 8'h00, 8'(deny));
  endtask : t_table

  task automatic t_strap;
    strap_n <= 1'b0;
    repeat (4) @(posedge clock);
    chk("ext only", 8'h00, 8'(ext_only));
    do_reset(1'b0);
    chk("ext only", 8'h01, 8'(ext_only));
    cpu_core_model_i.tread(16'h0000, 16'h0000, 16'h0100, g);
    chk("grant", 8'h00, 8'(g));
    cpu_core_model_i.nv_write(16'h8000, 8'hFF);
    settle;
    chk("flag", 8'h01, 8'(flag));
    cpu_core_model_i.nv_write(16'h8000, 8'h00);
    settle;
    chk("flag", 8'h01, 8'(flag));
    chk("deny", 8'h01, 8'(deny));
  endtask : t_strap

  // ==========
  // run and verdict
  task automatic end_sim;
    $display("bad_count=%0d checks=%0d", bad_count, checks);
    if (bad_count == 0 && checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : end_sim

  always @(posedge clock) begin
    cycles++;
    if (cycles == 20000) begin
      bad_count++;
      end_sim;
    end
  end

  initial begin
    do_reset(1'b1);
    t_regs;
    t_vote;
    t_lock;
    t_erase;
    t_busy;
    t_table;
    t_strap;
    end_sim;
  end
endmodule : testbench
`default_nettype wire
